// *** rtl/otg_line_pkg.sv ***
package otg_line_pkg;

    // ----------------------------------------
    // Register map, byte addresses on the bus.
    // ----------------------------------------
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  CTRL_ADDR   = 4'h0;
    localparam logic [3:0]  STATUS_ADDR = 4'h4;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam int          CTRL_W      = 10;

    // Control register field positions.
    localparam int C_PULLUP    = 0;
    localparam int C_PD_PLUS   = 1;
    localparam int C_PD_MINUS  = 2;
    localparam int C_AUTO_EN   = 3;
    localparam int C_WEAK_PU   = 4;
    localparam int C_BYP_DIS   = 5;
    localparam int C_AUDIO_EN  = 6;
    localparam int C_DDA_EN    = 7;
    localparam int C_SUSPEND   = 8;
    localparam int C_DATA_AND_SINGLE_ENDED_ZERO_ENCODING   = 9;

    // Status register field positions; bits 0 and 1 are sticky, write one to clear.
    localparam int S_CARKIT    = 0;
    localparam int S_STEREO    = 1;
    localparam int S_AUTO_ON   = 2;
    localparam int S_NRZ       = 3;
    localparam int S_TX_BUSY   = 4;

    // ----------------------------------------
    // Timing.
    // ----------------------------------------
    localparam int CLK_NS          = 8;
    localparam int AUDIO_TICK_NS   = 320;
    localparam int AUDIO_TICK_CYC  = AUDIO_TICK_NS / CLK_NS;
    localparam int STEREO_QUAL_MS  = 30;
    localparam int NRZ_IDLE_MS     = 20;
    localparam int STEREO_QUAL_TICKS = (STEREO_QUAL_MS * 1000000 + AUDIO_TICK_NS - 1)
                                       / AUDIO_TICK_NS;
    localparam int NRZ_IDLE_TICKS  = (NRZ_IDLE_MS * 1000000 + AUDIO_TICK_NS - 1)
                                     / AUDIO_TICK_NS;
    localparam int POS_PULSE_TICKS = 1;
    localparam int NEG_PULSE_TICKS = 1;

    // ----------------------------------------
    // Pin inputs, all from outside the clock domain.
    // ----------------------------------------
    typedef struct packed {
        logic por;
        logic rx_active;
        logic supply_low;
        logic carkit_below;
        logic line_minus;
        logic line_plus;
        logic reset_pin_n;
        logic output_enable_n;
        logic zero_or_minus_pin;
        logic data_or_plus_pin;
    } pin_in_s;

    localparam int PIN_W = 10;
    // Lines in J with the driver off, so no edge or SE0 is seen as reset ends.
    localparam logic [PIN_W-1:0] PIN_IDLE = 10'h01c;

    // Transmit pulse generator states.
    typedef enum logic [4:0] {
        P_IDLE = 5'b00001,
        P_ARM  = 5'b00010,
        P_HIGH = 5'b00100,
        P_LOW  = 5'b01000,
        P_REL  = 5'b10000
    } pulse_state_e;

endpackage : otg_line_pkg

// *** rtl/otg_line_ctrl.sv ***
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
// Behaviour
// - Main plus-line pull-up switch closes while the pull-up enable bit is set or the autoconnect pull-up is on.
// - Idle pull-up switch closes when the main pull-up is on and bus idle, opens while transmitting or receiving.
// - Weak plus-line pull-up follows its enable bit.
// - Plus-line pull-down follows its enable bit.
// - Minus-line pull-down follows its enable bit.
// - Low supply with bypass-disable clear bypasses the regulator; set keeps regulating.
// - Carkit line comparator is only heeded while audio mode is on.
// - Comparator reporting the carkit pin low sets the carkit line interrupt flag.
// - Free-running audio timer with 200 to 500 ns period is the time base.
// - Transmit pulse generator starts only while data-during-audio is on.
// - Each minus-pin edge: speaker off, buffer on, high, low, buffer off, speaker on.
// - Carkit pin continuously low for the qualify time raises a stereo interrupt.
// - Each negative pulse on the plus line inverts the NRZ output.
// - NRZ output low for the idle timeout is forced back to one.
// - Pull-up must follow the far end's release within 3 ms, in hardware.
// - With autoconnect enabled and not driving, SE0 turns the plus pull-up on.
// - Clearing autoconnect enable removes the automatically asserted pull-up.
// - Driver is high impedance when output enable is off or any reset is active.
// - Direct encoding drives plus from data pin and minus from minus pin.
// - Data/SE0 encoding: SE0 drives both low, else differential from data.
// - In suspend the driver is differential from the data pin in either encoding.
module otg_line_ctrl #(
    parameter int STEREO_TICKS = otg_line_pkg::STEREO_QUAL_TICKS,
    parameter int NRZ_TICKS    = otg_line_pkg::NRZ_IDLE_TICKS
) (
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Register bus, Avalon-MM slave.
    input  wire logic [otg_line_pkg::ADDR_W-1:0] address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [31:0]               writedata,
    output logic [31:0]                    readdata,
    output logic                           waitrequest,
    // Pins and analog comparators.
    input  wire otg_line_pkg::pin_in_s     pins,
    // Resistor switches and regulator.
    output logic                           main_pullup_switch,
    output logic                           idle_pullup_switch,
    output logic                           weak_pullup_switch,
    output logic                           plus_pulldown_switch,
    output logic                           minus_pulldown_switch,
    output logic                           regulator_bypass,
    // Differential driver.
    output logic                           plus_out,
    output logic                           plus_oe,
    output logic                           minus_out,
    output logic                           minus_oe,
    // Data-during-audio path.
    output logic                           speaker_buffer_enable,
    output logic                           txd_buffer_enable,
    output logic                           txd_level,
    output logic                           nrz_out,
    output logic                           stereo_interrupt
);

    // ----------------------------------------
    // Pin synchronisers.
    // ----------------------------------------
    logic [otg_line_pkg::PIN_W-1:0] s1_q, s2_q, s3_q, filt_q;
    otg_line_pkg::pin_in_s          pin;

    // A change is accepted only when the second and third stages agree.
    genvar gi;
    generate
        for (gi = 0; gi < otg_line_pkg::PIN_W; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (reset) begin
                    s1_q[gi]   <= otg_line_pkg::PIN_IDLE[gi];
                    s2_q[gi]   <= otg_line_pkg::PIN_IDLE[gi];
                    s3_q[gi]   <= otg_line_pkg::PIN_IDLE[gi];
                    filt_q[gi] <= otg_line_pkg::PIN_IDLE[gi];
                end else begin
                    s1_q[gi] <= pins[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        filt_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate
    assign pin = filt_q;

    // ----------------------------------------
    // Register bus.
    // ----------------------------------------
    logic [otg_line_pkg::CTRL_W-1:0] ctrl_q;
    logic                            carkit_flag_q, stereo_flag_q, auto_q;
    logic                            wait_q;
    logic [31:0]                     rdata_q;
    logic                            wr_ok, rd_sel_ctrl, rd_sel_stat;
    logic                            carkit_set, stereo_set;
    otg_line_pkg::pulse_state_e      pstate_q;
    logic                            nrz_q;

    // Every access is answered one cycle after it is seen; waitrequest falls for one cycle.
    assign wr_ok       = write && !wait_q;
    assign rd_sel_ctrl = (address == otg_line_pkg::CTRL_ADDR);
    assign rd_sel_stat = (address == otg_line_pkg::STATUS_ADDR);

    always_ff @(posedge clk) begin
        if (reset) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !((read || write) && wait_q);
        end
    end

    // Read data is captured while waitrequest is still high; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (read && wait_q) begin
            rdata_q <= 32'h0000_0000;
            if (rd_sel_ctrl) begin
                rdata_q[otg_line_pkg::CTRL_W-1:0] <= ctrl_q;
            end else if (rd_sel_stat) begin
                rdata_q[otg_line_pkg::S_CARKIT]  <= carkit_flag_q;
                rdata_q[otg_line_pkg::S_STEREO]  <= stereo_flag_q;
                rdata_q[otg_line_pkg::S_AUTO_ON] <= auto_q;
                rdata_q[otg_line_pkg::S_NRZ]     <= nrz_q;
                rdata_q[otg_line_pkg::S_TX_BUSY] <= (pstate_q != otg_line_pkg::P_IDLE);
            end
        end
    end
    assign readdata    = rdata_q;
    assign waitrequest = wait_q;

    // Control bits; writes to unmapped addresses are dropped.
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= otg_line_pkg::CTRL_RESET[otg_line_pkg::CTRL_W-1:0];
        end else if (wr_ok && rd_sel_ctrl) begin
            ctrl_q <= writedata[otg_line_pkg::CTRL_W-1:0];
        end
    end

    // Sticky flags: an event in the clearing cycle wins over the clear.
    always_ff @(posedge clk) begin
        if (reset) begin
            carkit_flag_q <= 1'b0;
            stereo_flag_q <= 1'b0;
        end else begin
            if (carkit_set) begin
                carkit_flag_q <= 1'b1;
            end else if (wr_ok && rd_sel_stat && writedata[otg_line_pkg::S_CARKIT]) begin
                carkit_flag_q <= 1'b0;
            end
            if (stereo_set) begin
                stereo_flag_q <= 1'b1;
            end else if (wr_ok && rd_sel_stat && writedata[otg_line_pkg::S_STEREO]) begin
                stereo_flag_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Audio timer and carkit detectors.
    // ----------------------------------------
    logic [7:0]  tmr_q;
    logic        tick_q;
    logic [23:0] stereo_cnt_q;
    logic        audio_on, dda_on;

    assign audio_on = ctrl_q[otg_line_pkg::C_AUDIO_EN];
    assign dda_on   = ctrl_q[otg_line_pkg::C_DDA_EN];

    // Free-running; the one-cycle tick paces the pulse widths and both long timeouts.
    always_ff @(posedge clk) begin
        if (reset) begin
            tmr_q  <= 8'h00;
            tick_q <= 1'b0;
        end else if (tmr_q == 8'(otg_line_pkg::AUDIO_TICK_CYC - 1)) begin
            tmr_q  <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            tmr_q  <= tmr_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    // The comparator is ignored outside audio mode.
    assign carkit_set = audio_on && pin.carkit_below;

    // Any return above threshold restarts the qualification.
    always_ff @(posedge clk) begin
        if (reset) begin
            stereo_cnt_q <= 24'h000000;
        end else if (!carkit_set) begin
            stereo_cnt_q <= 24'h000000;
        end else if (tick_q && stereo_cnt_q != 24'(STEREO_TICKS)) begin
            stereo_cnt_q <= stereo_cnt_q + 24'h000001;
        end
    end
    assign stereo_set = carkit_set && (stereo_cnt_q == 24'(STEREO_TICKS));

    // ----------------------------------------
    // Transmit pulse generator.
    // ----------------------------------------
    logic       minus_d1_q, minus_edge;
    logic [7:0] pw_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            minus_d1_q <= 1'b0;
        end else begin
            minus_d1_q <= pin.zero_or_minus_pin;
        end
    end
    assign minus_edge = dda_on && (minus_d1_q != pin.zero_or_minus_pin);

    // Edges arriving mid-sequence are not queued; at UART rates they cannot occur.
    always_ff @(posedge clk) begin
        if (reset) begin
            pstate_q <= otg_line_pkg::P_IDLE;
            pw_q     <= 8'h00;
        end else begin
            unique case (pstate_q)
                otg_line_pkg::P_IDLE: begin
                    if (minus_edge) begin
                        pstate_q <= otg_line_pkg::P_ARM;
                    end
                end
                otg_line_pkg::P_ARM: begin
                    if (tick_q) begin
                        pstate_q <= otg_line_pkg::P_HIGH;
                        pw_q     <= 8'(otg_line_pkg::POS_PULSE_TICKS);
                    end
                end
                otg_line_pkg::P_HIGH: begin
                    if (tick_q) begin
                        if (pw_q == 8'h01) begin
                            pstate_q <= otg_line_pkg::P_LOW;
                            pw_q     <= 8'(otg_line_pkg::NEG_PULSE_TICKS);
                        end else begin
                            pw_q <= pw_q - 8'h01;
                        end
                    end
                end
                otg_line_pkg::P_LOW: begin
                    if (tick_q) begin
                        if (pw_q == 8'h01) begin
                            pstate_q <= otg_line_pkg::P_REL;
                        end else begin
                            pw_q <= pw_q - 8'h01;
                        end
                    end
                end
                otg_line_pkg::P_REL: begin
                    if (tick_q) begin
                        pstate_q <= otg_line_pkg::P_IDLE;
                    end
                end
            endcase
        end
    end

    // Buffer controls are registered off the state so they change one cycle after it.
    always_ff @(posedge clk) begin
        if (reset) begin
            speaker_buffer_enable <= 1'b1;
            txd_buffer_enable     <= 1'b0;
            txd_level             <= 1'b0;
        end else begin
            speaker_buffer_enable <= (pstate_q == otg_line_pkg::P_IDLE);
            txd_buffer_enable     <= (pstate_q == otg_line_pkg::P_HIGH) ||
                                     (pstate_q == otg_line_pkg::P_LOW);
            txd_level             <= (pstate_q == otg_line_pkg::P_HIGH);
        end
    end

    // ----------------------------------------
    // Receive pulse to NRZ converter.
    // ----------------------------------------
    logic        plus_d1_q;
    logic [23:0] nrz_cnt_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            plus_d1_q <= 1'b1;
        end else begin
            plus_d1_q <= pin.line_plus;
        end
    end

    // Falling plus line marks a received pulse; a long low is forced back to one.
    always_ff @(posedge clk) begin
        if (reset) begin
            nrz_q     <= 1'b1;
            nrz_cnt_q <= 24'h000000;
        end else if (dda_on && plus_d1_q && !pin.line_plus) begin
            nrz_q     <= !nrz_q;
            nrz_cnt_q <= 24'h000000;
        end else if (nrz_q) begin
            nrz_cnt_q <= 24'h000000;
        end else if (nrz_cnt_q == 24'(NRZ_TICKS)) begin
            nrz_q     <= 1'b1;
            nrz_cnt_q <= 24'h000000;
        end else if (tick_q) begin
            nrz_cnt_q <= nrz_cnt_q + 24'h000001;
        end
    end
    assign nrz_out          = nrz_q;
    assign stereo_interrupt = stereo_flag_q;

    // ----------------------------------------
    // Autoconnect, switches and regulator.
    // ----------------------------------------
    logic auto_en, line_se0, drive_en;

    assign auto_en  = ctrl_q[otg_line_pkg::C_AUTO_EN];
    assign line_se0 = !pin.line_plus && !pin.line_minus;
    assign drive_en = !pin.output_enable_n && pin.reset_pin_n && !pin.por;

    // Reacts within a few cycles of SE0, far inside the 3 ms budget, with no bus access.
    always_ff @(posedge clk) begin
        if (reset) begin
            auto_q <= 1'b0;
        end else if (!auto_en) begin
            auto_q <= 1'b0;
        end else if (pin.output_enable_n && line_se0) begin
            auto_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            main_pullup_switch    <= 1'b0;
            idle_pullup_switch    <= 1'b0;
            weak_pullup_switch    <= 1'b0;
            plus_pulldown_switch  <= 1'b0;
            minus_pulldown_switch <= 1'b0;
            regulator_bypass      <= 1'b0;
        end else begin
            main_pullup_switch    <= ctrl_q[otg_line_pkg::C_PULLUP] || auto_q;
            idle_pullup_switch    <= (ctrl_q[otg_line_pkg::C_PULLUP] || auto_q) &&
                                     !drive_en && !pin.rx_active;
            weak_pullup_switch    <= ctrl_q[otg_line_pkg::C_WEAK_PU];
            plus_pulldown_switch  <= ctrl_q[otg_line_pkg::C_PD_PLUS];
            minus_pulldown_switch <= ctrl_q[otg_line_pkg::C_PD_MINUS];
            regulator_bypass      <= pin.supply_low &&
                                     !ctrl_q[otg_line_pkg::C_BYP_DIS];
        end
    end

    // ----------------------------------------
    // Differential driver.
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            plus_out  <= 1'b0;
            minus_out <= 1'b0;
            plus_oe   <= 1'b0;
            minus_oe  <= 1'b0;
        end else begin
            plus_oe  <= drive_en;
            minus_oe <= drive_en;
            if (ctrl_q[otg_line_pkg::C_SUSPEND]) begin
                plus_out  <= pin.data_or_plus_pin;
                minus_out <= !pin.data_or_plus_pin;
            end else if (ctrl_q[otg_line_pkg::C_DATA_AND_SINGLE_ENDED_ZERO_ENCODING]) begin
                plus_out  <= pin.data_or_plus_pin && !pin.zero_or_minus_pin;
                minus_out <= !pin.data_or_plus_pin && !pin.zero_or_minus_pin;
            end else begin
                plus_out  <= pin.data_or_plus_pin;
                minus_out <= pin.zero_or_minus_pin;
            end
        end
    end

    // ----------------------------------------
    // Checks.
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Longest gap between two audio ticks, in clock cycles.
    localparam int TICK_SPAN = otg_line_pkg::AUDIO_TICK_CYC;

    main_pullup_off_a: assert property (
        !ctrl_q[otg_line_pkg::C_PULLUP] && !auto_q |=> !main_pullup_switch)
        else $error("main pull-up closed without enable");
    idle_switch_busy_a: assert property (
        pin.rx_active |=> !idle_pullup_switch)
        else $error("idle pull-up closed while bus busy");
    weak_pullup_a: assert property (
        weak_pullup_switch == $past(ctrl_q[otg_line_pkg::C_WEAK_PU]))
        else $error("weak pull-up does not follow its bit");
    regulator_bypass_a: assert property (
        pin.supply_low && !ctrl_q[otg_line_pkg::C_BYP_DIS] |=> regulator_bypass)
        else $error("regulator not bypassed at low supply");
    carkit_flag_a: assert property (
        audio_on && pin.carkit_below |=> carkit_flag_q)
        else $error("carkit flag not set");
    audio_tick_a: assert property (
        tick_q |=> !tick_q ##[1:TICK_SPAN] tick_q)
        else $error("audio tick period wrong");
    pulse_high_a: assert property (
        pstate_q == otg_line_pkg::P_ARM && tick_q |=> ##1 txd_buffer_enable && txd_level)
        else $error("positive pulse not driven");
    nrz_toggle_a: assert property (
        dda_on && plus_d1_q && !pin.line_plus |=> nrz_q != $past(nrz_q))
        else $error("nrz not inverted on pulse");
    driver_hiz_a: assert property (
        pin.output_enable_n |=> !plus_oe && !minus_oe)
        else $error("driver enabled while output enable off");
    se0_drive_a: assert property (
        !ctrl_q[otg_line_pkg::C_SUSPEND] && ctrl_q[otg_line_pkg::C_DATA_AND_SINGLE_ENDED_ZERO_ENCODING] &&
        pin.zero_or_minus_pin |=> !plus_out && !minus_out)
        else $error("SE0 not driven");
    auto_connect_a: assert property (
        auto_en && pin.output_enable_n && line_se0 |=> auto_q ##1 main_pullup_switch)
        else $error("autoconnect did not close pull-up");
    auto_release_a: assert property (
        !auto_en |=> !auto_q)
        else $error("auto pull-up not released");

    pulse_seq_c: cover property (pstate_q == otg_line_pkg::P_REL ##1
                                 pstate_q == otg_line_pkg::P_IDLE);
    nrz_timeout_c: cover property (!nrz_q ##1 nrz_q && !$past(dda_on && plus_d1_q));
    auto_on_c: cover property ($rose(auto_q));
    stereo_c: cover property ($rose(stereo_flag_q));

endmodule : otg_line_ctrl

// *** verif/otg_host_model.sv ***
`timescale 1ns/1ns
module otg_host_model (
    // Clock.
    input  wire logic             clk,
    // Pins toward the transceiver.
    output otg_line_pkg::pin_in_s pins
);
    // Lines start in the J state with the driver off, so no SE0 is seen by accident.
    initial pins = otg_line_pkg::pin_in_s'(10'h01c);

    // Every change lands just after an edge, as the controller's own flops would drive it.
    task automatic put(input logic [9:0] v);
        @(posedge clk);
        pins <= otg_line_pkg::pin_in_s'(v);
    endtask : put
endmodule : otg_host_model

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb;
    localparam logic [9:0] J = 10'h01c;
    logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
    logic [3:0]  address = 4'h0;
    logic [31:0] writedata = 32'h0, rd, readdata;
    logic        waitrequest, mps, ips, wps, pps, nps, byp, po, poe, mo, moe;
    logic        spk, txb, txl, nrz, ster, ep, em;
    otg_line_pkg::pin_in_s pins;
    int          miscompares = 0, samples_checked = 0, hi, lo;

    // Free-running 125 MHz clock.
    always #4 clk = ~clk;

    otg_line_ctrl #(.STEREO_TICKS(4), .NRZ_TICKS(4)) otg_line_ctrl_inst (
        .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .pins(pins),
        .main_pullup_switch(mps), .idle_pullup_switch(ips), .weak_pullup_switch(wps),
        .plus_pulldown_switch(pps), .minus_pulldown_switch(nps), .regulator_bypass(byp),
        .plus_out(po), .plus_oe(poe), .minus_out(mo), .minus_oe(moe),
        .speaker_buffer_enable(spk), .txd_buffer_enable(txb), .txd_level(txl),
        .nrz_out(nrz), .stereo_interrupt(ster));
    otg_host_model otg_host_model_inst (.clk(clk), .pins(pins));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One bus access; the request is held until waitrequest is sampled low.
    task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : acc

    task automatic ctl(input logic [31:0] d);
        acc(1'b1, otg_line_pkg::CTRL_ADDR, d);
        // The auto pull-up path has two flops after the bit, so wait three edges.
        repeat (3) @(posedge clk);
    endtask : ctl

    // Pins pass a three-flop synchroniser, so allow ten edges before looking.
    task automatic pin(input logic [9:0] v);
        otg_host_model_inst.put(v);
        repeat (10) @(posedge clk);
    endtask : pin

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // Watchdog: the tests need well under ten thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        acc(1'b0, otg_line_pkg::CTRL_ADDR, 32'h0);
        chk(rd, otg_line_pkg::CTRL_RESET);
        acc(1'b0, 4'hc, 32'h0);
        chk(rd, 32'h0);
        chk({mps, wps, pps, nps, byp}, 5'h00);
        ctl(32'h17);
        pin(J);
        chk({mps, wps, pps, nps, ips}, 5'h1f);
        pin(J | 10'h100);
        chk(ips, 1'b0);
        ctl(32'h0);
        chk({mps, wps, pps, nps, ips}, 5'h00);
        pin(J | 10'h080);
        chk(byp, 1'b1);
        ctl(32'h20);
        chk(byp, 1'b0);
        $display("test switches done");
        for (int m = 0; m < 3; m++) begin
            ctl(m == 1 ? 32'h200 : (m == 2 ? 32'h100 : 32'h0));
            for (int v = 0; v < 4; v++) begin
                pin(10'h018 | 10'(v));
                ep = (m == 1) ? (v[0] & ~v[1]) : v[0];
                em = (m == 0) ? v[1] : ((m == 1) ? ~(v[0] | v[1]) : ~v[0]);
                chk({po, mo, poe, moe}, {ep, em, 2'b11});
            end
        end
        pin(10'h218);
        chk({poe, moe}, 2'b00);
        pin(10'h010);
        chk({poe, moe}, 2'b00);
        $display("test driver done");
        pin(J);
        ctl(32'h8); // Autoconnect is armed while the lines still show J.
        pin(10'h00c);
        chk(mps, 1'b1);
        acc(1'b0, otg_line_pkg::STATUS_ADDR, 32'h0);
        chk(rd[otg_line_pkg::S_AUTO_ON], 1'b1);
        ctl(32'h0);
        chk(mps, 1'b0);
        pin(J | 10'h040);
        repeat (300) @(posedge clk);
        acc(1'b0, otg_line_pkg::STATUS_ADDR, 32'h0);
        chk({ster, rd[1:0]}, 3'b000);
        ctl(32'h40);
        repeat (300) @(posedge clk);
        acc(1'b0, otg_line_pkg::STATUS_ADDR, 32'h0);
        chk({ster, rd[1:0]}, 3'b111);
        $display("test carkit done");
        pin(J);
        ctl(32'h80);
        pin(10'h00c);
        pin(J);
        chk(nrz, 1'b0);
        repeat (300) @(posedge clk);
        chk(nrz, 1'b1);
        // A minus-pin edge with the path off must not pulse; with it on, one tick high.
        for (int e = 0; e < 2; e++) begin
            ctl(e ? 32'h80 : 32'h0);
            hi = 0;
            lo = 0;
            otg_host_model_inst.put(e ? J : J | 10'h002);
            repeat (300) begin
                @(posedge clk);
                hi += int'(txl & txb);
                lo += int'(!spk);
            end
            chk(hi >= 38 && hi <= 42 && lo > hi, e);
            chk(spk, 1'b1);
        end
        $display("test audio path done");
        wrap_up();
    end
endmodule : tb
